// ---- hdl/priv_mode_pkg.sv ----
package priv_mode_pkg;

   // Width of a stack pointer word.
   localparam int SP_WIDTH = 32;
   // Operating-mode control bit positions.
   localparam int CTRL_USER_BIT = 0;
   localparam int CTRL_ALT_STACK_BIT = 1;
   localparam int CTRL_WIDTH = 2;
   // Number of low stack pointer bits forced to zero.
   localparam int SP_ALIGN_BITS = 2;
   // Reset values.
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [31:0] SP_RESET = 32'h0000_0000;

   // Combined level and mode, one-hot.
   typedef enum logic [2:0]
   {
      ST_PRIV_THREAD = 3'b001,
      ST_PRIV_HANDLER = 3'b010,
      ST_USER_THREAD = 3'b100
   } op_state_e;

endpackage : priv_mode_pkg

// ---- hdl/privilege_mode_tracker.sv ----
// Summary of operation
// - Only three states: privileged handler, privileged thread, user thread.
// - Handler mode while servicing an exception, thread mode otherwise.
// - User level blocks restricted instructions, special and config registers, debug.
// - A blocked user-level access raises a fault instead of being performed.
// - Privileged level permits every access with no access fault.
// - Two separate stack pointers, main and process, are held.
// - Process stack pointer used only in user thread mode, main otherwise.
// - Control bit 0: zero privileged thread, one user thread.
// - Control bit 1 is stored but does not select the stack in any mode; cleared on exception entry, held zero in handler.
// - Low two stack pointer bits are ignored and read as zero.
module privilege_mode_tracker
(
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Exception sequencing from the core.
   input wire logic exc_entry,
   input wire logic exc_return,
   // Control register write (privileged thread only).
   input wire logic ctrl_wr,
   input wire logic [priv_mode_pkg::CTRL_WIDTH-1:0] ctrl_wdata,
   // Stack pointer write to the active pointer.
   input wire logic sp_wr,
   input wire logic [priv_mode_pkg::SP_WIDTH-1:0] sp_wdata,
   // Access check request.
   input wire logic acc_req,
   input wire logic acc_restricted,
   // Status outputs.
   output logic [2:0] op_state,
   output logic privileged,
   output logic handler_mode,
   output logic [priv_mode_pkg::CTRL_WIDTH-1:0] ctrl_value,
   output logic use_process_sp,
   output logic [priv_mode_pkg::SP_WIDTH-1:0] active_sp,
   output logic [priv_mode_pkg::SP_WIDTH-1:0] main_stack_pointer,
   output logic [priv_mode_pkg::SP_WIDTH-1:0] process_stack_pointer,
   // Access result, one cycle after the request.
   output logic acc_grant,
   output logic acc_fault
);
   import priv_mode_pkg::*;

   op_state_e state_reg;
   op_state_e state_next;
   logic [CTRL_WIDTH-1:0] ctrl_reg;
   logic [CTRL_WIDTH-1:0] ctrl_next;
   logic [SP_WIDTH-1:0] msp_reg;
   logic [SP_WIDTH-1:0] psp_reg;
   logic grant_reg;
   logic fault_reg;
   logic user_now;
   logic psp_sel;
   logic [SP_WIDTH-1:0] sp_aligned;

   // Control writes take effect only from privileged thread code; user code cannot
   // raise its own level, which is why a user-level write is refused below.
   assign user_now = (state_reg == ST_USER_THREAD);
   assign sp_aligned = {sp_wdata[SP_WIDTH-1:SP_ALIGN_BITS], {SP_ALIGN_BITS{1'b0}}};

   // Next state from exception entry, return and control bit 0.
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_PRIV_THREAD:
         begin
            if (exc_entry)
               state_next = ST_PRIV_HANDLER;
            else if (ctrl_wr && ctrl_wdata[CTRL_USER_BIT])
               state_next = ST_USER_THREAD;
         end
         ST_PRIV_HANDLER:
         begin
            if (exc_return && !exc_entry)
               state_next = ctrl_reg[CTRL_USER_BIT] ? ST_USER_THREAD : ST_PRIV_THREAD;
         end
         ST_USER_THREAD:
         begin
            if (exc_entry)
               state_next = ST_PRIV_HANDLER;
         end
         default:
            state_next = ST_PRIV_THREAD;
      endcase
   end

   // State register.
   always_ff @(posedge clk)
   begin
      if (reset)
         state_reg <= ST_PRIV_THREAD;
      else
         state_reg <= state_next;
   end

   // Next control bits; bit 1 is cleared on exception entry because handler has no alternate stack.
   always_comb
   begin
      ctrl_next = ctrl_reg;
      if (exc_entry)
         ctrl_next[CTRL_ALT_STACK_BIT] = 1'b0;
      else if (ctrl_wr && state_reg == ST_PRIV_THREAD)
         ctrl_next = ctrl_wdata;
   end

   // Control register.
   always_ff @(posedge clk)
   begin
      if (reset)
         ctrl_reg <= CTRL_RESET;
      else
         ctrl_reg <= ctrl_next;
   end

   assign psp_sel = (state_next == ST_USER_THREAD);

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         msp_reg <= SP_RESET;
         psp_reg <= SP_RESET;
      end
      else if (sp_wr && !exc_entry)
      begin
         if (user_now)
            psp_reg <= sp_aligned;
         else
            msp_reg <= sp_aligned;
      end
   end

   // Access check: a restricted access at user level faults, everything else is granted.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         grant_reg <= 1'b0;
         fault_reg <= 1'b0;
      end
      else
      begin
         grant_reg <= acc_req && !(user_now && acc_restricted);
         fault_reg <= acc_req && user_now && acc_restricted;
      end
   end

   // Registered outputs.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         op_state <= ST_PRIV_THREAD;
         privileged <= 1'b1;
         handler_mode <= 1'b0;
         use_process_sp <= 1'b0;
      end
      else
      begin
         op_state <= state_next;
         privileged <= (state_next != ST_USER_THREAD);
         handler_mode <= (state_next == ST_PRIV_HANDLER);
         use_process_sp <= psp_sel;
      end
   end

   // Stack mirrors lag their holding registers by one cycle. The control mirror and the stack
   // selection use next-cycle values, so these outputs never disagree with the shown mode.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ctrl_value <= CTRL_RESET;
         main_stack_pointer <= SP_RESET;
         process_stack_pointer <= SP_RESET;
         active_sp <= SP_RESET;
      end
      else
      begin
         ctrl_value <= ctrl_next;
         main_stack_pointer <= msp_reg;
         process_stack_pointer <= psp_reg;
         active_sp <= psp_sel ? psp_reg : msp_reg;
      end
   end

   assign acc_grant = grant_reg;
   assign acc_fault = fault_reg;

   // Entry sequence: exception taken, handler shown next cycle.
   sequence s_entry;
      exc_entry ##1 handler_mode;
   endsequence

   property p_one_hot;
      @(posedge clk) disable iff (reset) $onehot(op_state);
   endproperty
   a_one_hot: assert property (p_one_hot) else $error("state not one of three");

   property p_entry;
      @(posedge clk) disable iff (reset) exc_entry |=> handler_mode && privileged;
   endproperty
   a_entry: assert property (p_entry) else $error("no handler after entry");

   property p_fault;
      @(posedge clk) disable iff (reset) (acc_req && !privileged && acc_restricted) |=> acc_fault && !acc_grant;
   endproperty
   a_fault: assert property (p_fault) else $error("blocked access not faulted");

   property p_priv_ok;
      @(posedge clk) disable iff (reset) (acc_req && privileged) |=> acc_grant && !acc_fault;
   endproperty
   a_priv_ok: assert property (p_priv_ok) else $error("privileged access faulted");

   property p_psp;
      @(posedge clk) disable iff (reset) use_process_sp == (!privileged && !handler_mode);
   endproperty
   a_psp: assert property (p_psp) else $error("wrong stack selected");

   property p_active_sel;
      @(posedge clk) disable iff (reset)
         active_sp == (use_process_sp ? process_stack_pointer : main_stack_pointer);
   endproperty
   a_active_sel: assert property (p_active_sel) else $error("active pointer disagrees with stack select");

   property p_alt_handler;
      @(posedge clk) disable iff (reset) handler_mode |-> !ctrl_value[CTRL_ALT_STACK_BIT];
   endproperty
   a_alt_handler: assert property (p_alt_handler) else $error("alt stack bit seen while in handler");

   property p_align;
      @(posedge clk) disable iff (reset) active_sp[1:0] == 2'h0;
   endproperty
   a_align: assert property (p_align) else $error("stack pointer misaligned");

   property p_alt_zero;
      @(posedge clk) disable iff (reset) s_entry |=> !ctrl_value[CTRL_ALT_STACK_BIT];
   endproperty
   a_alt_zero: assert property (p_alt_zero) else $error("alt stack bit set in handler");

   property p_user_wr;
      @(posedge clk) disable iff (reset)
         (ctrl_wr && ctrl_wdata[CTRL_USER_BIT] && op_state == ST_PRIV_THREAD && !exc_entry) |=> !privileged;
   endproperty
   a_user_wr: assert property (p_user_wr) else $error("bit 0 did not drop to user");

   property p_reset;
      @(posedge clk) reset |=> privileged && !handler_mode && ctrl_value == CTRL_RESET;
   endproperty
   a_reset: assert property (p_reset) else $error("bad reset state");

endmodule : privilege_mode_tracker

// ---- tb/tb_top.sv ----
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import priv_mode_pkg::*;
   logic clk = 1'h0;
   logic reset = 1'h1;
   logic exc_entry = 1'h0, exc_return = 1'h0, ctrl_wr = 1'h0, sp_wr = 1'h0, acc_req = 1'h0, acc_restricted = 1'h0;
   logic [CTRL_WIDTH-1:0] ctrl_wdata = 2'h0;
   logic [SP_WIDTH-1:0] sp_wdata = 32'h0000_0000;
   logic [2:0] op_state;
   logic privileged, handler_mode, use_process_sp, acc_grant, acc_fault, seen_f;
   logic [CTRL_WIDTH-1:0] ctrl_value;
   logic [SP_WIDTH-1:0] active_sp, main_stack_pointer, process_stack_pointer, exp_msp, exp_psp;
   logic note_q[$];
   int fail_count = 0;
   int checks = 0;

   privilege_mode_tracker privilege_mode_tracker_inst (.clk, .reset, .exc_entry, .exc_return, .ctrl_wr,
      .ctrl_wdata, .sp_wr, .sp_wdata, .acc_req, .acc_restricted, .op_state, .privileged, .handler_mode,
      .ctrl_value, .use_process_sp, .active_sp, .main_stack_pointer, .process_stack_pointer, .acc_grant,
      .acc_fault);

   // The clock toggles every half period of 2 ns.
   always #2 clk = ~clk;

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // One full view of the level, mode, control and both stacks.
   task automatic st(input logic [2:0] s, input logic [1:0] c);
      chk("op_state", {29'h0, s}, {29'h0, op_state});
      chk("privileged", {31'h0, s != ST_USER_THREAD}, {31'h0, privileged});
      chk("handler_mode", {31'h0, s == ST_PRIV_HANDLER}, {31'h0, handler_mode});
      chk("use_process_sp", {31'h0, s == ST_USER_THREAD}, {31'h0, use_process_sp});
      chk("ctrl_value", {30'h0, c}, {30'h0, ctrl_value});
      chk("main_stack_pointer", exp_msp, main_stack_pointer);
      chk("process_stack_pointer", exp_psp, process_stack_pointer);
      chk("active_sp", (s == ST_USER_THREAD) ? exp_psp : exp_msp, active_sp);
   endtask : st

   // Requests stay up between calls so that back-to-back checks need no idle cycle.
   task automatic acc(input logic r, input logic f);
      acc_req = 1'h1;
      acc_restricted = r;
      note_q.push_back(f);
      cyc(1);
   endtask : acc

   task automatic wr_sp(input logic [31:0] d);
      sp_wr = 1'h1;
      sp_wdata = d;
      cyc(1);
      sp_wr = 1'h0;
      cyc(3);
   endtask : wr_sp

   task automatic wr_ctrl(input logic [1:0] c);
      ctrl_wr = 1'h1;
      ctrl_wdata = c;
      cyc(1);
      ctrl_wr = 1'h0;
      cyc(3);
   endtask : wr_ctrl

   task automatic wrap_up;
      if (fail_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up

   // Each access answer is matched against the oldest note; a stray answer counts as a mismatch.
   always @(negedge clk)
      if (!reset && (acc_grant !== 1'h0 || acc_fault !== 1'h0))
      begin
         if (note_q.size() == 0)
            chk("acc_unexpected", 32'h0000_0000, 32'h0000_0001);
         else
         begin
            seen_f = note_q.pop_front();
            chk("acc_fault", {31'h0, seen_f}, {31'h0, acc_fault});
            chk("acc_grant", {31'h0, !seen_f}, {31'h0, acc_grant});
         end
      end

   // Main sequence; the pointer values are random so the alignment mask is exercised broadly.
   initial
   begin
      void'($urandom(32'h0000_65b5));
      exp_msp = SP_RESET;
      exp_psp = SP_RESET;
      cyc(20);
      reset = 1'h0;
      st(ST_PRIV_THREAD, 2'h0);
      exp_msp = $urandom;
      wr_sp(exp_msp);
      exp_msp[1:0] = 2'h0;
      st(ST_PRIV_THREAD, 2'h0);
      acc(1'h1, 1'h0);
      acc(1'h0, 1'h0);
      acc_req = 1'h0;
      wr_ctrl(2'h3);
      st(ST_USER_THREAD, 2'h3);
      exp_psp = $urandom;
      wr_sp(exp_psp);
      exp_psp[1:0] = 2'h0;
      st(ST_USER_THREAD, 2'h3);
      acc(1'h1, 1'h1);
      acc(1'h0, 1'h0);
      acc(1'h1, 1'h1);
      acc_req = 1'h0;
      wr_ctrl(2'h0);
      st(ST_USER_THREAD, 2'h3);
      exc_entry = 1'h1;
      cyc(1);
      exc_entry = 1'h0;
      cyc(3);
      st(ST_PRIV_HANDLER, 2'h1);
      acc(1'h1, 1'h0);
      acc_req = 1'h0;
      exc_return = 1'h1;
      cyc(1);
      exc_return = 1'h0;
      cyc(3);
      st(ST_USER_THREAD, 2'h1);
      reset = 1'h1;
      cyc(2);
      reset = 1'h0;
      exp_msp = SP_RESET;
      exp_psp = SP_RESET;
      cyc(1);
      st(ST_PRIV_THREAD, 2'h0);
      // Alternate-stack bit in privileged thread, a stray return, then entry must clear the bit.
      wr_ctrl(2'h2);
      exc_return = 1'h1;
      cyc(1);
      exc_return = 1'h0;
      st(ST_PRIV_THREAD, 2'h2);
      exc_entry = 1'h1;
      cyc(1);
      exc_entry = 1'h0;
      exp_msp = $urandom;
      wr_sp(exp_msp);
      exp_msp[1:0] = 2'h0;
      st(ST_PRIV_HANDLER, 2'h0);
      exc_return = 1'h1;
      cyc(1);
      exc_return = 1'h0;
      cyc(3);
      st(ST_PRIV_THREAD, 2'h0);
      for (int i = 0; i < 10 && note_q.size() > 0; i++)
         cyc(1);
      chk("notes_left", 32'h0000_0000, note_q.size());
      wrap_up();
   end
endmodule : tb_top
